// ==== core/flash_cmd_addr_regs.sv ====
// Command and start-address registers with busy/ready tracking
//
// Functional notes
// - Start address holds 6-bit page and 2-bit sector, both reset zero.
// - Sector count gives sectors to move; 00 (reset) means four.
// - Buffer sector index steps, low two bits wrap 11 to 00.
// - Select bit3 boot/data, bit2 data bank, bits1:0 sector.
// - Auto mode: command at ready clears flag; completion sets it.
// - While busy only core reset and hot reset are accepted.
// - 0000h loads main sectors, 0013h loads spare sectors.
// - 0080h programs main+spare, 001Ah spare, 001Bh copy-back.
// - Unlock one, lock one, lock-tight one, unlock all commands.
// - 000Eh cache read start, 000Ch finish, 000Ah burst block read.
// - 00F0h resets core; 00F3h returns all registers to default except the status sector field, which loads the old start select.
// - With polarity bit 6 set (reset), interrupt pin low while busy, high when ready, by flag.
// - Interrupt and ready pins stay undriven until enable bit set.
//
// Local design decision: the Wishbone register port.
`default_nettype none
`include "flash_cmd_consts.svh"
module flash_cmd_addr_regs
  import flash_cmd_pkg::*;
(
  // Clocking
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Wishbone slave
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  output logic irq_pin_o,
  output logic irq_pin_oe,
  output logic rdy_pin_o,
  output logic rdy_pin_oe,
  // Buffer sector being moved
  output logic [3:0] buf_sector_o,
  output logic buf_sector_valid_o
);
  // ==========================================================
  // Bus decode
  wire [31:0] byte_adr = wb_adr_i;
  wire [29:0] widx = byte_adr[31:2];
  wire hit_sps = (widx == 30'(`REG_START_PAGE_SECTOR_IDX));
  wire hit_bss = (widx == 30'(`REG_BUFFER_START_SELECT_IDX));
  wire hit_cmd = (widx == 30'(`REG_COMMAND_CODE_IDX));
  wire hit_irq = (widx == 30'(`REG_IRQ_STATUS_IDX));
  wire hit_cfg = (widx == 30'(`REG_SYS_CONFIG_IDX));
  wire hit_ctl = (widx == 30'(`REG_OP_CONTROL_IDX));
  wire hit_sts = (widx == 30'(`REG_OP_STATUS_IDX));
  wire hit_rsv = (widx == 30'(`REG_START_ADDR_SLOT_IDX));
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  wire wr = req && wb_we_i;
  wire lo_lane = wb_sel_i[0];
  wire hi_lane = wb_sel_i[1];

  logic [15:0] sps_ff;
  logic [15:0] bss_ff;
  logic [15:0] cmd_ff;
  logic [15:0] cfg_ff;
  logic [15:0] ctl_ff;
  logic ready_ff;
  op_state_t state_ff;
  logic [2:0] left_ff;
  logic [7:0] tick_ff;
  logic sector_valid_ff;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
    input logic lo, input logic hi);
    merge = {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // Command acceptance
  op_class_t cls;
  logic is_hot;
  cmd_decoder u_dec
  (
    .code(merge(cmd_ff, wb_dat_i, lo_lane, hi_lane)),
    .op_class(cls),
    .hot(is_hot)
  );
  wire busy = (state_ff != st_idle);
  wire cmd_wr = wr && hit_cmd;
  wire auto_mode = ctl_ff[`FLD_AUTO_MODE_BIT];
  wire cmd_ok = cmd_wr && (!busy || cls == op_reset);
  wire hot_go = cmd_ok && is_hot;
  wire [2:0] bsc_sectors = (bss_ff[1:0] == 2'h0) ? 3'h4 : {1'b0, bss_ff[1:0]};
  wire done = (state_ff == st_done);

  // ==========================================================
  // Register writes
  wire [15:0] nxt_sps = merge(sps_ff, wb_dat_i, lo_lane, hi_lane) & 16'h00ff;
  wire [15:0] nxt_bss = merge(bss_ff, wb_dat_i, lo_lane, hi_lane) & 16'h0f03;
  wire [15:0] nxt_cfg = merge(cfg_ff, wb_dat_i, lo_lane, hi_lane) & 16'h0060;
  wire [15:0] nxt_ctl = merge(ctl_ff, wb_dat_i, lo_lane, hi_lane) & 16'h0001;
  always_ff @(posedge ref_clk)
  begin
    if (reset || (clk_en && hot_go))
    begin
      sps_ff <= `RST_START_PAGE_SECTOR;
      bss_ff <= `RST_BUFFER_START_SELECT;
      cmd_ff <= `RST_COMMAND_CODE;
      cfg_ff <= `RST_SYS_CONFIG;
      ctl_ff <= `RST_OP_CONTROL;
    end
    else if (clk_en)
    begin
      if (wr && hit_sps)
        sps_ff <= nxt_sps;
      if (wr && hit_bss)
        bss_ff <= nxt_bss;
      if (cmd_ok)
        cmd_ff <= merge(cmd_ff, wb_dat_i, lo_lane, hi_lane);
      if (wr && hit_cfg)
        cfg_ff <= nxt_cfg;
      if (wr && hit_ctl)
        ctl_ff <= nxt_ctl;
    end
  end

  // ==========================================================
  // Completion flag: completion wins over a manual clear in the same cycle
  wire man_clr = wr && hit_irq && lo_lane == 1'b0 && hi_lane && !wb_dat_i[`FLD_IRQ_READY_BIT];
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ready_ff <= 1'b1;
    else if (clk_en)
    begin
      if (done)
        ready_ff <= 1'b1;
      else if (cmd_ok && auto_mode && ready_ff)
        ready_ff <= 1'b0;
      else if (man_clr)
        ready_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Operation sequencer
  sector_walker u_walk
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .load(cmd_ok),
    .start_sel(bss_ff[11:8]),
    .step((state_ff == st_sector) && tick_ff == 8'h0 && left_ff != 3'h1),
    .cur_sel_ff(buf_sector_o)
  );
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_ff <= st_idle;
      left_ff <= 3'h0;
      tick_ff <= 8'h0;
      sector_valid_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (cmd_ok && cls == op_reset)
      begin
        state_ff <= st_reset;
        tick_ff <= 8'(`OP_CYCLES - 1);
        sector_valid_ff <= 1'b0;
      end
      else if (cmd_ok)
      begin
        sector_valid_ff <= (cls == op_transfer);
        left_ff <= bsc_sectors;
        tick_ff <= (cls == op_transfer) ? 8'(`SECTOR_CYCLES - 1) : 8'(`OP_CYCLES - 1);
        state_ff <= (cls == op_transfer) ? st_sector : st_wait;
      end
      else
      begin
        case (state_ff)
          st_sector:
          begin
            if (tick_ff != 8'h0)
              tick_ff <= tick_ff - 8'h1;
            else if (left_ff == 3'h1)
            begin
              state_ff <= st_done;
              sector_valid_ff <= 1'b0;
            end
            else
            begin
              left_ff <= left_ff - 3'h1;
              tick_ff <= 8'(`SECTOR_CYCLES - 1);
            end
          end
          st_wait, st_reset:
          begin
            if (tick_ff != 8'h0)
              tick_ff <= tick_ff - 8'h1;
            else
              state_ff <= st_done;
          end
          st_done:
            state_ff <= st_idle;
          default:
            state_ff <= st_idle;
        endcase
      end
    end
  end

  // ==========================================================
  // Pins, registered; both held undriven until the enable bit is set
  wire out_en = cfg_ff[`FLD_OUT_EN_BIT];
  wire int_lvl = cfg_ff[`FLD_INT_POL_BIT] ? ready_ff : !ready_ff;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      irq_pin_o <= 1'b0;
      irq_pin_oe <= 1'b0;
      rdy_pin_o <= 1'b0;
      rdy_pin_oe <= 1'b0;
      buf_sector_valid_o <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_pin_o <= int_lvl;
      irq_pin_oe <= out_en;
      rdy_pin_o <= !busy;
      rdy_pin_oe <= out_en;
      buf_sector_valid_o <= sector_valid_ff;
    end
  end

  // ==========================================================
  // Read mux and acknowledge; unmapped reads return zero
  buf_sel_t cur_sel;
  assign cur_sel = {1'b0, buf_sector_o};
  wire [15:0] irq_val = {ready_ff, 15'h0};
  wire [15:0] sts_val = {8'h0, cur_sel.boot_data[0], cur_sel.data_bank, cur_sel.sector,
    1'b0, state_ff};
  wire [15:0] rd_val = hit_sps ? sps_ff : hit_bss ? bss_ff : hit_cmd ? cmd_ff :
    hit_irq ? irq_val : hit_cfg ? cfg_ff : hit_ctl ? ctl_ff : hit_sts ? sts_val :
    hit_rsv ? 16'h0000 : 16'h0000;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else if (clk_en)
    begin
      wb_ack_o <= req;
      wb_dat_o <= req ? {16'h0, rd_val} : 32'h0;
    end
  end
endmodule
`default_nettype wire

// ==== core/flash_cmd_consts.svh ====
// Register offsets, field positions, reset values and timing counts of the command block
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

// Register indices (word index; byte address is four times the index)
`define REG_START_ADDR_SLOT_IDX 16'hf106
`define REG_START_PAGE_SECTOR_IDX 16'hf107
`define REG_BUFFER_START_SELECT_IDX 16'hf200
`define REG_COMMAND_CODE_IDX 16'hf220
`define REG_IRQ_STATUS_IDX 16'hf241
`define REG_SYS_CONFIG_IDX 16'hf221
`define REG_OP_CONTROL_IDX 16'hf300
`define REG_OP_STATUS_IDX 16'hf301

// Field positions
`define FLD_SECTOR_LSB 0
`define FLD_PAGE_LSB 2
`define FLD_BSC_LSB 0
`define FLD_BSA_LSB 8
`define FLD_IRQ_READY_BIT 15
`define FLD_INT_POL_BIT 6
`define FLD_OUT_EN_BIT 5
`define FLD_AUTO_MODE_BIT 0

// Reset values
`define RST_START_PAGE_SECTOR 16'h0000
`define RST_BUFFER_START_SELECT 16'h0000
`define RST_COMMAND_CODE 16'h0000
`define RST_SYS_CONFIG 16'h0040
`define RST_OP_CONTROL 16'h0001

// Command codes
`define CMD_LOAD_MAIN 16'h0000
`define CMD_LOAD_SPARE 16'h0013
`define CMD_PROG_MAIN 16'h0080
`define CMD_PROG_SPARE 16'h001a
`define CMD_COPY_BACK 16'h001b
`define CMD_UNLOCK_ONE 16'h0023
`define CMD_LOCK_ONE 16'h002a
`define CMD_LOCK_TIGHT 16'h002c
`define CMD_UNLOCK_ALL 16'h0027
`define CMD_CACHE_START 16'h000e
`define CMD_CACHE_FINISH 16'h000c
`define CMD_BURST_BLOCK 16'h000a
`define CMD_CORE_RESET 16'h00f0
`define CMD_HOT_RESET 16'h00f3

// Timing: emulated array time per sector and per operation
`define SECTOR_TIME_NS 100
`define OP_TIME_NS 200
`define SECTOR_CYCLES ((`SECTOR_TIME_NS + 9) / 10)
`define OP_CYCLES ((`OP_TIME_NS + 9) / 10)

`endif

// ==== core/flash_cmd_pkg.sv ====
// Types shared by the command block files
`default_nettype none
package flash_cmd_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_sector = 3'b001,
    st_wait = 3'b010,
    st_reset = 3'b011,
    st_done = 3'b100
  } op_state_t;

  typedef enum logic [2:0] {
    op_none = 3'b000,
    op_transfer = 3'b001,
    op_lock = 3'b010,
    op_read = 3'b011,
    op_reset = 3'b100,
    op_unknown = 3'b101
  } op_class_t;

  typedef struct packed {
    logic [1:0] boot_data;
    logic data_bank;
    logic [1:0] sector;
  } buf_sel_t;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
    logic err;
  } wb_rsp_t;
endpackage
`default_nettype wire

// ==== core/cmd_decoder.sv ====
// Command code classifier
`default_nettype none
`include "flash_cmd_consts.svh"
module cmd_decoder
  import flash_cmd_pkg::*;
(
  // Command in
  input wire logic [15:0] code,
  // Class out
  output op_class_t op_class,
  output logic hot
);
  wire is_xfer = (code == `CMD_LOAD_MAIN) || (code == `CMD_LOAD_SPARE)
    || (code == `CMD_PROG_MAIN) || (code == `CMD_PROG_SPARE)
    || (code == `CMD_COPY_BACK);
  wire is_lock = (code == `CMD_UNLOCK_ONE) || (code == `CMD_LOCK_ONE)
    || (code == `CMD_LOCK_TIGHT) || (code == `CMD_UNLOCK_ALL);
  wire is_read = (code == `CMD_CACHE_START) || (code == `CMD_CACHE_FINISH)
    || (code == `CMD_BURST_BLOCK);
  wire is_rst = (code == `CMD_CORE_RESET) || (code == `CMD_HOT_RESET);
  assign hot = (code == `CMD_HOT_RESET);
  assign op_class = is_xfer ? op_transfer : is_lock ? op_lock : is_read ? op_read :
    is_rst ? op_reset : op_unknown;
endmodule
`default_nettype wire

// ==== core/sector_walker.sv ====
// Buffer sector index stepper with wrap inside the chosen buffer
`default_nettype none
module sector_walker
(
  // Clocking
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Control
  input wire logic load,
  input wire logic [3:0] start_sel,
  input wire logic step,
  // State
  output logic [3:0] cur_sel_ff
);
  wire [1:0] nxt_low = cur_sel_ff[1:0] + 2'h1;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      cur_sel_ff <= 4'h0;
    else if (clk_en && load)
      cur_sel_ff <= start_sel;
    else if (clk_en && step)
      cur_sel_ff <= {cur_sel_ff[3:2], nxt_low};
  end
endmodule
`default_nettype wire

// ==== sim/flash_cmd_addr_regs_sva.sv ====
// Port checks for the command block
`default_nettype none
module flash_cmd_addr_regs_sva
(
  // Clocking
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Bus
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins
  input wire logic irq_pin_oe,
  input wire logic rdy_pin_o,
  input wire logic rdy_pin_oe,
  input wire logic [3:0] buf_sector_o,
  input wire logic buf_sector_valid_o
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ====
  // Helpers
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  wire logic cmd_wr = take && wb_we_i && wb_adr_i[31:2] == 30'hf220;
  wire logic oe_wr = wb_cyc_i && wb_we_i && wb_adr_i[31:2] == 30'hf221 && wb_dat_i[5];
  logic [3:0] prev_ff;
  always_ff @(posedge ref_clk) prev_ff <= buf_sector_o;
  property p_ack; take |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_rd_hi; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read half not zero");
  property p_oe_pair; irq_pin_oe == rdy_pin_oe; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("pin enables differ");
  property p_oe_cause; $rose(rdy_pin_oe) |-> $past(oe_wr) || $past(oe_wr, 2); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pins enabled unasked");
  property p_busy_start; cmd_wr && rdy_pin_o |-> ##[1:3] !rdy_pin_o; endproperty
  a_busy_start: assert property (p_busy_start) else $error("command left ready");
  property p_busy_end; $fell(rdy_pin_o) |-> ##[1:200] rdy_pin_o; endproperty
  a_busy_end: assert property (p_busy_end) else $error("operation never ends");
  property p_walk;
    buf_sector_valid_o && $past(buf_sector_valid_o) && buf_sector_o != prev_ff
      |-> buf_sector_o == {prev_ff[3:2], prev_ff[1:0] + 2'h1};
  endproperty
  a_walk: assert property (p_walk) else $error("sector step wrong");
  property p_valid_busy; buf_sector_valid_o |-> !rdy_pin_o; endproperty
  a_valid_busy: assert property (p_valid_busy) else $error("ready during transfer");
endmodule
bind flash_cmd_addr_regs flash_cmd_addr_regs_sva i_sva (.ref_clk, .reset, .clk_en,
  .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .irq_pin_oe, .rdy_pin_o, .rdy_pin_oe, .buf_sector_o, .buf_sector_valid_o);
`default_nettype wire

// ==== sim/wb_host_model.sv ====
// Host controller model: classic Wishbone master
`default_nettype none
module wb_host_model
(
  // Clocking
  input wire logic ref_clk,
  // Wishbone master
  output logic [31:0] wb_adr_o,
  output logic [31:0] wb_dat_o,
  output logic [3:0] wb_sel_o,
  output logic wb_we_o,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Byte lanes of the next request; a narrow mask is needed for the flag clear
  logic [3:0] sel_mask = 4'h3;
  initial
  begin
    {wb_adr_o, wb_dat_o, wb_sel_o, wb_we_o, wb_cyc_o, wb_stb_o} = '0;
  end
  // ====
  // One cycle; call right after a rising edge
  task automatic xfer(input logic [15:0] idx, input logic we, input logic [15:0] wd,
    output logic [15:0] rdv, output logic ok);
    int n;
    n = 0;
    wb_adr_o <= {14'h0, idx, 2'b00};
    wb_dat_o <= {16'h0, wd};
    wb_sel_o <= sel_mask;
    wb_we_o <= we;
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wb_ack_i !== 1'b1 && n < 50);
    ok = (wb_ack_i === 1'b1);
    rdv = wb_dat_i[15:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // Released lines must not keep looking valid
    wb_adr_o <= ~wb_adr_o;
    wb_dat_o <= ~wb_dat_o;
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ==== sim/flash_cmd_addr_regs_tb.sv ====
// Self-checking bench for the command and start-address registers
`default_nettype none
module flash_cmd_addr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [31:0] adr, wdat, rdat;
  logic [3:0] sel, bsec;
  logic we, cyc, stb, ack, irq, irq_oe, rdy, rdy_oe, bvalid, ok;
  logic [15:0] rv;
  logic [3:0] seen_q[$];
  int err_total = 0;
  int n_compared = 0;
  logic [15:0] codes [12] = '{16'h0000, 16'h0013, 16'h0080, 16'h001a, 16'h001b, 16'h0023,
    16'h002a, 16'h002c, 16'h0027, 16'h000e, 16'h000c, 16'h000a};
  // No spare data moves here, so program commands carry no read-only bytes
  logic [15:0] sels [12] = '{16'h0d00, 16'h0e01, 16'h0302, 16'h0803, 16'h0700, 16'h0800,
    16'h0800, 16'h0800, 16'h0800, 16'h0800, 16'h0800, 16'h0c00};
  flash_cmd_addr_regs i_dut (.ref_clk, .reset, .clk_en, .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_pin_o(irq), .irq_pin_oe(irq_oe), .rdy_pin_o(rdy),
    .rdy_pin_oe(rdy_oe), .buf_sector_o(bsec), .buf_sector_valid_o(bvalid));
  wb_host_model i_host (.ref_clk, .wb_adr_o(adr), .wb_dat_o(wdat), .wb_sel_o(sel),
    .wb_we_o(we), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_dat_i(rdat), .wb_ack_i(ack));
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // ====
  // Tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    i_host.xfer(idx, 1'b1, d, rv, ok);
    chk("ack", {15'h0, ok}, 16'h1);
  endtask
  task automatic rd_chk(input string what, input logic [15:0] idx, input logic [15:0] exp);
    i_host.xfer(idx, 1'b0, 16'h0, rv, ok);
    chk(what, rv, exp);
  endtask
  task automatic wait_rdy;
    for (int c = 0; c < 300 && rdy !== 1'b1; c++) @(posedge ref_clk);
    chk("ready", {15'h0, rdy}, 16'h1);
  endtask
  task automatic run_cmd(input logic [15:0] code, input logic [15:0] sv, input bit moves);
    int n;
    n = (sv[1:0] == 2'h0) ? 4 : sv[1:0];
    wr(16'hf200, sv);
    wr(16'hf220, code);
    chk("busy", {14'h0, irq, rdy}, 16'h0);
    seen_q.delete();
    for (int c = 0; c < 300 && rdy !== 1'b1; c++)
    begin
      @(posedge ref_clk);
      if (bvalid === 1'b1 && (seen_q.size() == 0 || seen_q[$] !== bsec))
        seen_q.push_back(bsec);
    end
    if (!moves)
      n = 0;
    chk("count", 16'(seen_q.size()), 16'(n));
    foreach (seen_q[i])
      chk("sector", {12'h0, seen_q[i]}, {12'h0, sv[11:10], sv[9:8] + 2'(i)});
    @(posedge ref_clk);
    chk("irq", {15'h0, irq}, 16'h1);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ====
  // Tests
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk("oe", {14'h0, irq_oe, rdy_oe}, 16'h0);
    rd_chk("page", 16'hf107, 16'h0000);
    rd_chk("bufsel", 16'hf200, 16'h0000);
    rd_chk("cmd", 16'hf220, 16'h0000);
    rd_chk("rsvd", 16'hf106, 16'h0000);
    wr(16'hf107, 16'hffff);
    rd_chk("page", 16'hf107, 16'h00ff);
    wr(16'hf200, 16'hffff);
    rd_chk("bufsel", 16'hf200, 16'h0f03);
    wr(16'h0123, 16'hffff);
    rd_chk("unmapped", 16'h0123, 16'h0000);
    $display("test registers done");
    wr(16'hf221, 16'h0060);
    chk("oe", {14'h0, irq_oe, rdy_oe}, 16'h3);
    wr(16'hf107, 16'h0000);
    for (int i = 0; i < 12; i++) run_cmd(codes[i], sels[i], i < 5);
    $display("test commands done");
    wr(16'hf200, 16'h0000);
    wr(16'hf220, 16'h0013);
    wr(16'hf220, 16'h0080);
    rd_chk("cmd", 16'hf220, 16'h0013);
    chk("busy", {15'h0, rdy}, 16'h0);
    wr(16'hf220, 16'h00f0);
    rd_chk("cmd", 16'hf220, 16'h00f0);
    wait_rdy;
    $display("test busy done");
    // Manual mode: clear the flag through the upper lane only, then issue a command
    wr(16'hf300, 16'h0000);
    i_host.sel_mask = 4'h2;
    wr(16'hf241, 16'h0000);
    i_host.sel_mask = 4'h3;
    chk("irq", {15'h0, irq}, 16'h0);
    rd_chk("flag", 16'hf241, 16'h0000);
    wr(16'hf200, 16'h0800);
    wr(16'hf220, 16'h0023);
    wait_rdy;
    chk("irq", {15'h0, irq}, 16'h1);
    rd_chk("flag", 16'hf241, 16'h8000);
    $display("test manual mode done");
    wr(16'hf107, 16'h00aa);
    wr(16'hf220, 16'h00f3);
    wait_rdy;
    rd_chk("page", 16'hf107, 16'h0000);
    chk("oe", {14'h0, irq_oe, rdy_oe}, 16'h0);
    rd_chk("mode", 16'hf300, 16'h0001);
    $display("test hot reset done");
    close_out;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    close_out;
  end
endmodule
`default_nettype wire
